// ---- core/ssq_scan_sequencer.sv ----
// How it works
// RULE1 - star bus route gets the step-done pulse before the next entry starts
// RULE2 - route also offers back, front and twelve unit lines each; only one driven
// RULE3 - each edge setting picks rising or falling as the active event
// RULE4 - neutral order adds new connections, leaves existing ones untouched
// RULE5 - open-first releases all old connections before closing new ones
// RULE6 - close-first closes all new connections before releasing old ones
// RULE7 - immediate source advances without waiting for any trigger
// RULE8 - external source holds at the wait point until an active edge arrives
// RULE9 - software source holds until host writes the trigger command
// RULE10 - trigger lines zero to seven selectable as the advance source
// RULE11 - star bus selectable as the advance source
// RULE12 - back, front and twelve unit lines per panel selectable as source
// RULE13 - pause only at entries flagged as trigger waits, then advance
// RULE14 - route none suppresses the step-done pulse on every line
// RULE15 - trigger lines zero to seven selectable as step-done destinations
// RULE16 - inputs synchronised, one event per edge, edges ignored unless waiting
// RULE17 - one pulse of chosen polarity after the entry's connections complete
//
// Our own choices: the address map and the AXI4-Lite slave port.
module ssq_scan_sequencer #(
  parameter int ENTRIES = 16,
  parameter int CONN_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ssq_pkg::NUM_LINES-1:0] trig_line_in,
  output logic [ssq_pkg::NUM_LINES-1:0] step_done_line_out,
  output logic [ssq_pkg::NUM_LINES-1:0] step_done_line_oe,
  output logic [CONN_W-1:0] connection_out
);
  localparam int IW = $clog2(ENTRIES);
  localparam int NL = ssq_pkg::NUM_LINES;

  if (ENTRIES < 2 || ENTRIES > 48 || CONN_W < 1 || CONN_W > 31) begin : g_check
    $error("ssq_scan_sequencer: ENTRIES must be 2..48 and CONN_W 1..31");
  end

  function automatic logic [31:0] ssq_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : ssq_merge

  // list window test in nine bits so the end of a full list cannot wrap to zero
  function automatic logic ssq_in_list(input logic [7:0] a);
    return {1'b0, a} >= {1'b0, ssq_pkg::ADDR_LIST} &&
           {1'b0, a} < {1'b0, ssq_pkg::ADDR_LIST} + 9'(4 * ENTRIES) && a[1:0] == 2'h0;
  endfunction : ssq_in_list

  // ---------------- bus slave ----------------
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] cfg_r, cfg_nxt;
  logic [IW:0] len_r, len_nxt;
  logic [31:0] len_word;
  logic [31:0] list_mem [ENTRIES];
  logic mem_we;
  logic [IW-1:0] mem_idx;
  logic wr_go, start_cmd, sw_trig_cmd, abort_cmd;

  // sequencer state, declared here because status reads it
  ssq_pkg::ssq_state_t state_r, state_nxt;
  logic [IW-1:0] idx_r, idx_nxt;
  logic done_r, done_nxt;

  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    cfg_nxt = cfg_r;
    len_nxt = len_r;
    len_word = ssq_merge({{(31-IW){1'b0}}, len_r}, wdata_r, wstrb_r);
    mem_we = 1'b0;
    mem_idx = awaddr_r[IW+1:2];
    start_cmd = 1'b0;
    sw_trig_cmd = 1'b0;
    abort_cmd = 1'b0;
    // address and data are taken independently, in either order
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      wready_nxt = 1'b0;
    end
    wr_go = aw_held_r && w_held_r && !bvalid_r;
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = ssq_pkg::RESP_OKAY;
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      if (awaddr_r == ssq_pkg::ADDR_CTRL) begin
        start_cmd = wstrb_r[0] && wdata_r[ssq_pkg::CTRL_START];
        sw_trig_cmd = wstrb_r[0] && wdata_r[ssq_pkg::CTRL_SW_TRIG]; // see RULE9
        abort_cmd = wstrb_r[0] && wdata_r[ssq_pkg::CTRL_ABORT];
      end else if (awaddr_r == ssq_pkg::ADDR_CONFIG) begin
        cfg_nxt = ssq_merge(cfg_r, wdata_r, wstrb_r) & ssq_pkg::CFG_MASK;
      end else if (awaddr_r == ssq_pkg::ADDR_STATUS) begin
        bresp_nxt = ssq_pkg::RESP_OKAY;
      end else if (awaddr_r == ssq_pkg::ADDR_LEN) begin
        len_nxt = len_word[IW:0];
      end else if (ssq_in_list(awaddr_r)) begin
        mem_we = 1'b1;
        mem_idx = IW'((awaddr_r - ssq_pkg::ADDR_LIST) >> 2);
      end else begin
        bresp_nxt = ssq_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = ssq_pkg::RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (s_axi_araddr == ssq_pkg::ADDR_CTRL) begin
        rdata_nxt = 32'h0000_0000;
      end else if (s_axi_araddr == ssq_pkg::ADDR_CONFIG) begin
        rdata_nxt = cfg_r;
      end else if (s_axi_araddr == ssq_pkg::ADDR_STATUS) begin
        rdata_nxt[ssq_pkg::STAT_RUNNING] = state_r != ssq_pkg::SSQ_IDLE;
        rdata_nxt[ssq_pkg::STAT_WAITING] = state_r == ssq_pkg::SSQ_WAIT;
        rdata_nxt[ssq_pkg::STAT_DONE] = done_r;
        rdata_nxt[ssq_pkg::STAT_IDX_LSB +: IW] = idx_r;
      end else if (s_axi_araddr == ssq_pkg::ADDR_LEN) begin
        rdata_nxt = 32'(len_r);
      end else if (ssq_in_list(s_axi_araddr)) begin
        rdata_nxt = list_mem[IW'((s_axi_araddr - ssq_pkg::ADDR_LIST) >> 2)];
      end else begin
        rresp_nxt = ssq_pkg::RESP_SLVERR;
      end
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= ssq_pkg::RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ssq_pkg::RESP_OKAY;
      cfg_r <= ssq_pkg::CFG_RESET;
      len_r <= '0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      cfg_r <= cfg_nxt;
      len_r <= len_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (mem_we) begin
      list_mem[mem_idx] <= ssq_merge(list_mem[mem_idx], wdata_r, wstrb_r);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ---------------- trigger inputs ----------------
  logic [NL-1:0] sync1_r, sync2_r, prev_r;
  logic [NL-1:0] act_edge;
  logic [5:0] src;
  logic line_hit, trig_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= trig_line_in; // see RULE16
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  always_comb begin
    src = cfg_r[ssq_pkg::CFG_SRC_LSB +: 6];
    // see RULE3
    act_edge = (cfg_r[ssq_pkg::CFG_SRC_EDGE] == ssq_pkg::EDGE_FALLING) ?
               (prev_r & ~sync2_r) : (sync2_r & ~prev_r);
    line_hit = 1'b0;
    // covers external, trigger lines, star, panel and unit lines; see RULE8 RULE10 RULE11 RULE12
    if (src >= ssq_pkg::SRC_LINE0 && src < ssq_pkg::SRC_LINE0 + 6'(NL)) begin
      line_hit = act_edge[src - ssq_pkg::SRC_LINE0];
    end
    trig_hit = (src == ssq_pkg::SRC_SOFTWARE) ? sw_trig_cmd : line_hit; // see RULE9
  end

  // ---------------- sequencer ----------------
  logic [CONN_W-1:0] conn_r, conn_nxt, entry_conn;
  logic entry_wait, last_entry;
  logic [$clog2(ssq_pkg::PULSE_CYCLES+1)-1:0] pcnt_r, pcnt_nxt;
  logic [1:0] order;

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    done_nxt = done_r;
    conn_nxt = conn_r;
    pcnt_nxt = pcnt_r;
    order = cfg_r[ssq_pkg::CFG_ORDER_LSB +: 2];
    entry_conn = list_mem[idx_r][CONN_W-1:0];
    entry_wait = list_mem[idx_r][ssq_pkg::ENTRY_WAIT];
    last_entry = 32'(idx_r) + 32'd1 >= 32'(len_r);
    case (state_r)
      ssq_pkg::SSQ_IDLE: begin
        if (start_cmd && len_r != '0) begin
          idx_nxt = '0;
          done_nxt = 1'b0;
          state_nxt = ssq_pkg::SSQ_STEP1;
        end
      end
      ssq_pkg::SSQ_STEP1: begin
        if (order == ssq_pkg::ORDER_OPEN_FIRST) begin
          conn_nxt = '0; // see RULE5
          state_nxt = ssq_pkg::SSQ_STEP2;
        end else if (order == ssq_pkg::ORDER_CLOSE_FIRST) begin
          conn_nxt = conn_r | entry_conn; // see RULE6
          state_nxt = ssq_pkg::SSQ_STEP2;
        end else begin
          conn_nxt = conn_r | entry_conn; // see RULE4
          pcnt_nxt = '0;
          state_nxt = ssq_pkg::SSQ_PULSE;
        end
      end
      ssq_pkg::SSQ_STEP2: begin
        // open-first makes the new set, close-first now drops the old one
        conn_nxt = entry_conn; // see RULE5 RULE6
        pcnt_nxt = '0;
        state_nxt = ssq_pkg::SSQ_PULSE;
      end
      ssq_pkg::SSQ_PULSE: begin
        pcnt_nxt = pcnt_r + 1'b1;
        if (32'(pcnt_r) == ssq_pkg::PULSE_CYCLES - 1) begin
          if (entry_wait && src != ssq_pkg::SRC_IMMEDIATE) begin // see RULE7 RULE13
            state_nxt = ssq_pkg::SSQ_WAIT;
          end else if (last_entry) begin
            done_nxt = 1'b1;
            state_nxt = ssq_pkg::SSQ_IDLE;
          end else begin
            idx_nxt = idx_r + 1'b1; // see RULE1
            state_nxt = ssq_pkg::SSQ_STEP1;
          end
        end
      end
      ssq_pkg::SSQ_WAIT: begin
        if (trig_hit) begin // see RULE13 RULE16
          if (last_entry) begin
            done_nxt = 1'b1;
            state_nxt = ssq_pkg::SSQ_IDLE;
          end else begin
            idx_nxt = idx_r + 1'b1;
            state_nxt = ssq_pkg::SSQ_STEP1;
          end
        end
      end
      default: state_nxt = ssq_pkg::SSQ_IDLE;
    endcase
    if (abort_cmd) begin
      state_nxt = ssq_pkg::SSQ_IDLE;
    end
  end

  // ---------------- step-done output ----------------
  logic [NL-1:0] out_r, out_nxt, oe_r, oe_nxt;
  logic [5:0] route;
  logic idle_lvl;

  always_comb begin
    route = cfg_r[ssq_pkg::CFG_ROUTE_LSB +: 6];
    idle_lvl = cfg_r[ssq_pkg::CFG_ROUTE_EDGE] == ssq_pkg::EDGE_FALLING; // see RULE3
    out_nxt = '0;
    oe_nxt = '0;
    // none or an unknown code leaves every line undriven; see RULE14
    if (route >= ssq_pkg::ROUTE_LINE0 && route < ssq_pkg::ROUTE_LINE0 + 6'(NL)) begin
      oe_nxt[route - ssq_pkg::ROUTE_LINE0] = 1'b1; // see RULE2 RULE15
      // pulse only after the entry's connections are in place; see RULE17 RULE1
      out_nxt[route - ssq_pkg::ROUTE_LINE0] = idle_lvl ^ (state_nxt == ssq_pkg::SSQ_PULSE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ssq_pkg::SSQ_IDLE;
      idx_r <= '0;
      done_r <= 1'b0;
      conn_r <= '0;
      pcnt_r <= '0;
      out_r <= '0;
      oe_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      done_r <= done_nxt;
      conn_r <= conn_nxt;
      pcnt_r <= pcnt_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign step_done_line_out = out_r;
  assign step_done_line_oe = oe_r;
  assign connection_out = conn_r;
endmodule : ssq_scan_sequencer

// ---- inc/ssq_pkg.sv ----
package ssq_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LEN = 8'h0C;
  localparam logic [7:0] ADDR_LIST = 8'h40;
  // control bits, write-one pulses
  localparam int CTRL_START = 0;
  localparam int CTRL_SW_TRIG = 1;
  localparam int CTRL_ABORT = 2;
  // config fields
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_SRC_EDGE = 6;
  localparam int CFG_ROUTE_LSB = 8;
  localparam int CFG_ROUTE_EDGE = 14;
  localparam int CFG_ORDER_LSB = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h0003_7F7F;
  // status fields
  localparam int STAT_RUNNING = 0;
  localparam int STAT_WAITING = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_IDX_LSB = 8;
  // list entry: connection pattern in the low bits, trigger-wait flag on top
  localparam int ENTRY_WAIT = 31;
  // trigger line map shared by inputs and outputs
  localparam int LINE_EXT = 0;
  localparam int LINE_TRIG0 = 1;
  localparam int LINE_STAR = 9;
  localparam int LINE_BACK = 10;
  localparam int LINE_FRONT = 11;
  localparam int LINE_BACK_UNIT0 = 12;
  localparam int LINE_FRONT_UNIT0 = 24;
  localparam int NUM_LINES = 36;
  // source code: 0 immediate, 1 software, SRC_LINE0 + line otherwise
  localparam logic [5:0] SRC_IMMEDIATE = 6'h00;
  localparam logic [5:0] SRC_SOFTWARE = 6'h01;
  localparam logic [5:0] SRC_LINE0 = 6'h02;
  // route code: 0 none, ROUTE_LINE0 + line otherwise
  localparam logic [5:0] ROUTE_NONE = 6'h00;
  localparam logic [5:0] ROUTE_LINE0 = 6'h01;
  // edge select
  localparam logic EDGE_RISING = 1'b0;
  localparam logic EDGE_FALLING = 1'b1;
  // connection order codes
  localparam logic [1:0] ORDER_NEUTRAL = 2'h0;
  localparam logic [1:0] ORDER_OPEN_FIRST = 2'h1;
  localparam logic [1:0] ORDER_CLOSE_FIRST = 2'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // step-done pulse length in cycles
  localparam int PULSE_CYCLES = 2;

  typedef enum logic [2:0] {
    SSQ_IDLE,
    SSQ_STEP1,
    SSQ_STEP2,
    SSQ_PULSE,
    SSQ_WAIT
  } ssq_state_t;
endpackage : ssq_pkg

// ---- tb/ssq_instrument.sv ----
module ssq_instrument (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [5:0] line,
  input wire logic falling,
  input wire logic [2:0] delay,
  output logic [ssq_pkg::NUM_LINES-1:0] trig_line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines rest inactive; one active edge per request after a variable delay
  always @(posedge aclk) begin
    if (fire) begin
      repeat (delay) @(posedge aclk);
      trig_line_in[line] <= !falling;
      repeat (4) @(posedge aclk);
    end
    trig_line_in <= {ssq_pkg::NUM_LINES{falling}};
  end
endmodule : ssq_instrument

// ---- tb/ssq_scan_sequencer_assertions.sv ----
module ssq_scan_sequencer_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ssq_pkg::NUM_LINES-1:0] step_done_line_out,
  input wire logic [ssq_pkg::NUM_LINES-1:0] step_done_line_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_quiet;
    $stable(step_done_line_oe) && step_done_line_oe != '0 && $stable(step_done_line_out);
  endsequence
  sequence s_edge;
    $stable(step_done_line_oe) && $changed(step_done_line_out);
  endsequence
  property p_pulse_len;
    s_quiet ##1 s_quiet ##1 s_edge |=> s_quiet ##1 s_edge;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("step pulse length wrong");
  property p_oe_one;
    $onehot0(step_done_line_oe);
  endproperty
  a_oe_one: assert property (p_oe_one) else $error("more than one line driven");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response timing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write channel not released");
  property p_r_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_time: assert property (p_r_time) else $error("read data timing");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read channel not released");
endmodule : ssq_scan_sequencer_assertions

bind ssq_scan_sequencer ssq_scan_sequencer_assertions i_ssq_scan_sequencer_assertions (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .step_done_line_out, .step_done_line_oe);

// ---- tb/test_scan_trigger_sequencer.sv ----
module test_scan_trigger_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NL = ssq_pkg::NUM_LINES;
  logic aclk, aresetn, fire, src_fall, out_fall, act, aprev;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [NL-1:0] trig_line_in, step_done_line_out, step_done_line_oe;
  logic [15:0] connection_out, cprev;
  logic [5:0] fline;
  logic [16:0] lg[$];
  int num_errors, num_checks, act_n, lag;
  logic [1:0] wr_resp;

  ssq_scan_sequencer #(.CONN_W(16)) i_ssq_scan_sequencer (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_line_in,
    .step_done_line_out, .step_done_line_oe, .connection_out);
  ssq_instrument i_ssq_instrument (.aclk, .fire, .line(fline), .falling(src_fall),
    .delay(fline[2:0]), .trig_line_in);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // log of connection changes and pulse starts, in the order they appear
  assign act = |((step_done_line_out ^ {NL{out_fall}}) & step_done_line_oe);
  always @(posedge aclk) begin
    cprev <= connection_out;
    aprev <= act;
    if (connection_out !== cprev) lg.push_back({1'b0, connection_out});
    if (act && !aprev) lg.push_back({1'b1, connection_out});
    if (act) act_n++;
  end

  task automatic end_sim;
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n >= lag && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      num_errors++;
      end_sim();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n >= lag && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      num_errors++;
      end_sim();
    end
  endtask : axi_rd

  task automatic poll(input int b);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    d = '0;
    for (n = 0; n < 60 && d[b] !== 1'b1; n++) axi_rd(ssq_pkg::ADDR_STATUS, d, r);
    if (d[b] !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask : poll

  task automatic run(input logic [31:0] cfg, input logic [31:0] e0, input logic [31:0] e1);
    axi_wr(ssq_pkg::ADDR_CONFIG, cfg);
    out_fall <= cfg[ssq_pkg::CFG_ROUTE_EDGE];
    axi_wr(ssq_pkg::ADDR_LIST, e0);
    axi_wr(ssq_pkg::ADDR_LIST + 8'h04, e1);
    axi_wr(ssq_pkg::ADDR_LEN, 32'h0000_0002);
    lg.delete();
    act_n = 0;
    axi_wr(ssq_pkg::ADDR_CTRL, 32'h0000_0001);
  endtask : run

  task automatic fire_line(input int ln);
    @(posedge aclk);
    fire <= 1'b1;
    fline <= 6'(ln);
    @(posedge aclk);
    fire <= 1'b0;
    repeat (16) @(posedge aclk);
  endtask : fire_line

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    // late ready makes the slave hold its responses
    lag = 3;
    axi_rd(ssq_pkg::ADDR_CONFIG, d, r);
    chk("config reset", ssq_pkg::CFG_RESET, d);
    axi_rd(8'h20, d, r);
    chk("unmapped read", {ssq_pkg::RESP_SLVERR, 32'h0}, {r, d});
    axi_wr(8'h20, 32'h0000_0001);
    chk("unmapped write", ssq_pkg::RESP_SLVERR, wr_resp);
    axi_wr(ssq_pkg::ADDR_CONFIG, 32'hFFFF_FFFF);
    chk("config write", ssq_pkg::RESP_OKAY, wr_resp);
    lag = 0;
    axi_rd(ssq_pkg::ADDR_CONFIG, d, r);
    chk("config mask", ssq_pkg::CFG_MASK, d);
  endtask : t_regs

  task automatic t_order;
    logic [16:0] ex[3][6];
    int k;
    int i;
    ex = '{'{17'h00003, 17'h10003, 17'h0000F, 17'h1000F, 17'h00000, 17'h00000},
           '{17'h00000, 17'h00003, 17'h10003, 17'h00000, 17'h0000C, 17'h1000C},
           '{17'h0000F, 17'h00003, 17'h10003, 17'h0000F, 17'h0000C, 17'h1000C}};
    for (k = 0; k < 3; k++) begin
      run(32'(k) << ssq_pkg::CFG_ORDER_LSB |
          32'(ssq_pkg::ROUTE_LINE0 + ssq_pkg::LINE_STAR) << ssq_pkg::CFG_ROUTE_LSB,
          32'h8000_0003, 32'h0000_000C);
      poll(ssq_pkg::STAT_DONE);
      chk("log length", (k == 0) ? 4 : 6, lg.size());
      for (i = 0; i < lg.size(); i++) chk("log", ex[k][i], lg[i]);
      chk("pulse cycles", 4 * ssq_pkg::PULSE_CYCLES / 2, act_n);
    end
  endtask : t_order

  task automatic t_routes;
    logic [NL-1:0] m;
    int r;
    for (r = 0; r <= NL; r++) begin
      m = (r == 0) ? '0 : NL'(1) << (r - 1);
      run(32'(r) << ssq_pkg::CFG_ROUTE_LSB | 32'(r % 2) << ssq_pkg::CFG_ROUTE_EDGE,
          32'h0000_0001, 32'h0000_0002);
      poll(ssq_pkg::STAT_DONE);
      chk("route enable", m, step_done_line_oe);
      chk("idle level", (r % 2) ? m : '0, step_done_line_out);
      chk("pulses", (r == 0) ? 0 : 2 * ssq_pkg::PULSE_CYCLES, act_n);
    end
  endtask : t_routes

  task automatic t_sources;
    int s;
    for (s = 1; s <= NL + 1; s++) begin
      src_fall <= 1'(s % 2);
      run(32'(s) | 32'(s % 2) << ssq_pkg::CFG_SRC_EDGE |
          32'(ssq_pkg::ORDER_OPEN_FIRST) << ssq_pkg::CFG_ORDER_LSB, 32'h8000_0001, 32'h2);
      poll(ssq_pkg::STAT_WAITING);
      if (s > 1) fire_line(s % NL);
      else repeat (16) @(posedge aclk);
      chk("held", 16'h0001, connection_out);
      if (s > 1) fire_line(s - 2);
      else axi_wr(ssq_pkg::ADDR_CTRL, 32'h0000_0002);
      poll(ssq_pkg::STAT_DONE);
      chk("advanced", 16'h0002, connection_out);
    end
  endtask : t_sources

  task automatic t_abort;
    logic [31:0] d;
    logic [1:0] r;
    run(32'(ssq_pkg::SRC_SOFTWARE) | 32'(ssq_pkg::ORDER_OPEN_FIRST) << ssq_pkg::CFG_ORDER_LSB,
        32'h8000_0005, 32'h0000_0002);
    poll(ssq_pkg::STAT_WAITING);
    axi_wr(ssq_pkg::ADDR_CTRL, 32'h0000_0004);
    axi_rd(ssq_pkg::ADDR_STATUS, d, r);
    chk("abort status", 32'h0000_0000, d);
    chk("abort keeps", 16'h0005, connection_out);
  endtask : t_abort

  initial begin
    aresetn = 1'b0;
    fire = 1'b0;
    fline = '0;
    src_fall = 1'b0;
    out_fall = 1'b0;
    lag = 0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_order();
    t_routes();
    t_sources();
    t_abort();
    end_sim();
  end
endmodule : test_scan_trigger_sequencer
